/* shared/bpp_pkg.sv */
// package for the board parallel port signal map block
package bpp_pkg;
  // register offsets (own choice, word index = byte address)
  localparam logic [1:0] OFS_PRINTER_DATA = 2'h0;
  localparam logic [1:0] OFS_STATUS_IN = 2'h1;
  localparam logic [1:0] OFS_BOARD_CTRL = 2'h2;
  localparam logic [1:0] OFS_CLK_SEL = 2'h3;
  // control port bit positions
  localparam int CTL_STROBE = 0;
  localparam int CTL_BUS_HOLD = 1;
  localparam int CTL_NMI_MASK = 2;
  localparam int CTL_NVRAM = 3;
  localparam int CTL_LED2 = 4;
  localparam int CTL_BUS_INT = 5;
  localparam int CTL_LOOPBACK = 6;
  localparam int CTL_LED1 = 7;
  // clock select bit positions
  localparam int CSEL_B_TX_EXT = 0;
  localparam int CSEL_B_RX_EXT = 1;
  localparam int CSEL_A_TX_EXT = 2;
  localparam int CSEL_A_RX_EXT = 3;
  // reset values
  localparam logic [7:0] RST_PRINTER_DATA = 8'h00;
  localparam logic [7:0] RST_BOARD_CTRL = 8'h4f;
  localparam logic [3:0] RST_CLK_SEL = 4'h0;

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bpp_bus_s;

  typedef struct packed {
    logic printer_occupied_n;
    logic printer_fault_n;
    logic power_fail_sense_n;
    logic printer_acknowledge_n;
    logic [3:0] gp_in;
  } bpp_status_s;
endpackage

/* hdl/bpp_port_map.sv */
// board parallel port signal map: printer data, status input, control output, clock select
`timescale 1ns/1ps
`default_nettype none
// How it works
// - data register bits 0..7 drive printer data bits 0..7 in order.
// - status bits 0..3 return four general-purpose input levels.
// - status bit 4 printer acknowledge, bit 5 power fail sense, both active low.
// - status bit 6 printer fault, bit 7 printer busy, both active low.
// - control bit 0 drives the active-low printer strobe.
// - control bit 1 zero holds system bus once obtained, one releases.
// - control bit 2 one disables NMI, zero enables it.
// - control bit 3 one enables NVRAM, zero clears timeout interrupt.
// - control bit 4 lights second red indicator; zero clears edge flag.
// - control bit 5 zero asserts the selected bus interrupt line.
// - control bit 6 one puts channel A in loopback, zero on-line.
// - control bit 7 lights first red indicator; zero clears acknowledge latch.
// - channel B transmit clock from timer counter 1 or external line.
// - channel A transmit clock from timer counter 2 or external line.
// - by default each receive clock follows its own transmit clock.
// - optionally each receive clock comes from connector transmit clock.
// - reset forces channel A loopback by setting control bit 6.
module bpp_port_map
  import bpp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // printer and status pins
  input wire logic [3:0] gp_in,
  input wire logic printer_acknowledge_n,
  input wire logic power_fail_sense_n,
  input wire logic printer_fault_n,
  input wire logic printer_occupied_n,
  output logic [7:0] printer_data,
  output logic printer_strobe_n,
  // board control outputs
  output logic bus_hold_release,
  output logic nmi_mask,
  output logic nvram_enable,
  output logic timeout_clear_n,
  output logic second_red_indicator,
  output logic edge_flag_clear_n,
  output logic bus_interrupt_n,
  output logic serial_loopback_select,
  output logic first_red_indicator,
  output logic ack_latch_clear_n,
  // serial clock sources
  input wire logic interval_timer_out1,
  input wire logic interval_timer_out2,
  input wire logic b_terminal_ready_clk,
  input wire logic b_ext_tx_clk,
  input wire logic a_terminal_ready_clk,
  input wire logic a_ext_tx_clk,
  output logic b_tx_clk,
  output logic b_rx_clk,
  output logic a_tx_clk,
  output logic a_rx_clk
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  bpp_status_s pin_now;
  bpp_status_s sync2;
  logic [7:0] stat_raw;
  logic [7:0] stat_s1;
  logic [7:0] stat_s2;
  logic [5:0] clk_raw;
  logic [5:0] clk_s1;
  logic [5:0] clk_s2;

  assign pin_now = '{printer_occupied_n: printer_occupied_n,
                     printer_fault_n: printer_fault_n,
                     power_fail_sense_n: power_fail_sense_n,
                     printer_acknowledge_n: printer_acknowledge_n,
                     gp_in: gp_in};
  assign clk_raw = {a_ext_tx_clk, a_terminal_ready_clk, interval_timer_out2,
                    b_ext_tx_clk, b_terminal_ready_clk, interval_timer_out1};
  assign stat_raw = pin_now;
  assign sync2 = stat_s2;

  // one pair per pin bit; nothing but stage two reads stage one
  for (genvar i = 0; i < 8; i++) begin : g_stat_sync
    always_ff @(posedge clk) begin
      stat_s1[i] <= stat_raw[i];
      stat_s2[i] <= stat_s1[i];
    end
  end

  for (genvar i = 0; i < 6; i++) begin : g_clk_sync
    always_ff @(posedge clk) begin
      clk_s1[i] <= clk_raw[i];
      clk_s2[i] <= clk_s1[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file
  logic [7:0] printer_data_output_port;
  logic [7:0] board_control_output_port;
  logic [3:0] clk_sel;
  logic [7:0] status_input_port;
  logic [7:0] csel_read;
  logic [7:0] next_rdata;
  logic wr_data;
  logic wr_ctrl;
  logic wr_csel;
  logic rd_data;
  logic rd_status;
  logic rd_ctrl;
  logic rd_csel;

  assign wr_data = wr && (addr == OFS_PRINTER_DATA);
  assign wr_ctrl = wr && (addr == OFS_BOARD_CTRL);
  assign wr_csel = wr && (addr == OFS_CLK_SEL);
  assign rd_data = rd && (addr == OFS_PRINTER_DATA);
  assign rd_status = rd && (addr == OFS_STATUS_IN);
  assign rd_ctrl = rd && (addr == OFS_BOARD_CTRL);
  assign rd_csel = rd && (addr == OFS_CLK_SEL);
  assign status_input_port = sync2;
  // upper select bits do not exist and read as zero
  assign csel_read = {4'h0, clk_sel};

  // idle cycles return zero, so a stale byte never looks like an answer
  assign next_rdata = ({8{rd_data}} & printer_data_output_port)
                    | ({8{rd_status}} & status_input_port)
                    | ({8{rd_ctrl}} & board_control_output_port)
                    | ({8{rd_csel}} & csel_read);

  always_ff @(posedge clk) begin
    if (rst) begin
      printer_data_output_port <= RST_PRINTER_DATA;
    end else if (wr_data) begin
      printer_data_output_port <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      board_control_output_port <= RST_BOARD_CTRL;
    end else if (wr_ctrl) begin
      board_control_output_port <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      clk_sel <= RST_CLK_SEL;
    end else if (wr_csel) begin
      clk_sel <= wdata[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive, all registered
  logic [7:0] next_printer_data;
  logic next_strobe_n;
  logic next_hold_release;
  logic next_nmi_mask;
  logic next_nvram_enable;
  logic next_timeout_clear_n;
  logic next_led2;
  logic next_edge_clear_n;
  logic next_bus_int_n;
  logic next_loopback;
  logic next_led1;
  logic next_ack_clear_n;
  logic [1:0] next_b_clk;
  logic [1:0] next_a_clk;
  logic b_tx_sel;
  logic a_tx_sel;

  assign next_printer_data = printer_data_output_port;
  assign next_strobe_n = board_control_output_port[CTL_STROBE];
  assign next_hold_release = board_control_output_port[CTL_BUS_HOLD];
  assign next_nmi_mask = board_control_output_port[CTL_NMI_MASK];
  assign next_nvram_enable = board_control_output_port[CTL_NVRAM];
  assign next_timeout_clear_n = board_control_output_port[CTL_NVRAM];
  assign next_led2 = board_control_output_port[CTL_LED2];
  assign next_edge_clear_n = board_control_output_port[CTL_LED2];
  assign next_bus_int_n = board_control_output_port[CTL_BUS_INT];
  assign next_loopback = board_control_output_port[CTL_LOOPBACK];
  assign next_led1 = board_control_output_port[CTL_LED1];
  assign next_ack_clear_n = board_control_output_port[CTL_LED1];

  assign b_tx_sel = clk_sel[CSEL_B_TX_EXT] ? clk_s2[1] : clk_s2[0];
  assign a_tx_sel = clk_sel[CSEL_A_TX_EXT] ? clk_s2[4] : clk_s2[3];
  assign next_b_clk = {clk_sel[CSEL_B_RX_EXT] ? clk_s2[2] : b_tx_sel, b_tx_sel};
  assign next_a_clk = {clk_sel[CSEL_A_RX_EXT] ? clk_s2[5] : a_tx_sel, a_tx_sel};

  // pins start from the control reset pattern, so they agree with a readback
  logic init_strobe_n;
  logic init_hold_release;
  logic init_nmi_mask;
  logic init_nvram;
  logic init_led2;
  logic init_bus_int_n;
  logic init_loopback;
  logic init_led1;
  assign init_strobe_n = RST_BOARD_CTRL[CTL_STROBE];
  assign init_hold_release = RST_BOARD_CTRL[CTL_BUS_HOLD];
  assign init_nmi_mask = RST_BOARD_CTRL[CTL_NMI_MASK];
  assign init_nvram = RST_BOARD_CTRL[CTL_NVRAM];
  assign init_led2 = RST_BOARD_CTRL[CTL_LED2];
  assign init_bus_int_n = RST_BOARD_CTRL[CTL_BUS_INT];
  assign init_loopback = RST_BOARD_CTRL[CTL_LOOPBACK];
  assign init_led1 = RST_BOARD_CTRL[CTL_LED1];

  always_ff @(posedge clk) begin
    if (rst) begin
      printer_data <= RST_PRINTER_DATA;
    end else begin
      printer_data <= next_printer_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      printer_strobe_n <= init_strobe_n;
    end else begin
      printer_strobe_n <= next_strobe_n;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bus_hold_release <= init_hold_release;
    end else begin
      bus_hold_release <= next_hold_release;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      nmi_mask <= init_nmi_mask;
    end else begin
      nmi_mask <= next_nmi_mask;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      nvram_enable <= init_nvram;
      timeout_clear_n <= init_nvram;
    end else begin
      nvram_enable <= next_nvram_enable;
      timeout_clear_n <= next_timeout_clear_n;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      second_red_indicator <= init_led2;
      edge_flag_clear_n <= init_led2;
    end else begin
      second_red_indicator <= next_led2;
      edge_flag_clear_n <= next_edge_clear_n;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bus_interrupt_n <= init_bus_int_n;
    end else begin
      bus_interrupt_n <= next_bus_int_n;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      serial_loopback_select <= init_loopback;
    end else begin
      serial_loopback_select <= next_loopback;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      first_red_indicator <= init_led1;
      ack_latch_clear_n <= init_led1;
    end else begin
      first_red_indicator <= next_led1;
      ack_latch_clear_n <= next_ack_clear_n;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      {b_rx_clk, b_tx_clk} <= 2'h0;
    end else begin
      {b_rx_clk, b_tx_clk} <= next_b_clk;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      {a_rx_clk, a_tx_clk} <= 2'h0;
    end else begin
      {a_rx_clk, a_tx_clk} <= next_a_clk;
    end
  end

endmodule
`default_nettype wire

/* testbench/bpp_chk.sv */
// assertions on the port map outputs
`timescale 1ns/1ps
`default_nettype none
module bpp_chk
  import bpp_pkg::*;
(
  // bus side
  input wire logic clk, rst, wr,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata, printer_data,
  // board control outputs
  input wire logic printer_strobe_n, bus_hold_release, nmi_mask, nvram_enable,
  input wire logic timeout_clear_n, second_red_indicator, edge_flag_clear_n,
  input wire logic bus_interrupt_n, serial_loopback_select, first_red_indicator,
  input wire logic ack_latch_clear_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire cw = wr && addr == OFS_BOARD_CTRL;
  wire dw = wr && addr == OFS_PRINTER_DATA;
  a_data_follow: assert property (dw |-> ##2 printer_data == $past(wdata, 2))
    else $error("printer data mismatch");
  a_strobe_bit: assert property (cw |-> ##2 printer_strobe_n == $past(wdata[0], 2))
    else $error("strobe mismatch");
  a_hold_bit: assert property (cw |-> ##2 bus_hold_release == $past(wdata[1], 2))
    else $error("bus hold mismatch");
  a_nmi_bit: assert property (cw |-> ##2 nmi_mask == $past(wdata[2], 2))
    else $error("nmi mask mismatch");
  a_nvram_pair: assert property (cw |-> ##2
    {nvram_enable, timeout_clear_n} == {2{$past(wdata[3], 2)}})
    else $error("nvram pair mismatch");
  a_led2_pair: assert property (cw |-> ##2
    {second_red_indicator, edge_flag_clear_n} == {2{$past(wdata[4], 2)}})
    else $error("edge clear pair mismatch");
  a_bus_int: assert property (cw |-> ##2 bus_interrupt_n == $past(wdata[5], 2))
    else $error("bus interrupt mismatch");
  a_loop_bit: assert property (cw |-> ##2 serial_loopback_select == $past(wdata[6], 2))
    else $error("loopback select mismatch");
  a_led1_pair: assert property (cw |-> ##2
    {first_red_indicator, ack_latch_clear_n} == {2{$past(wdata[7], 2)}})
    else $error("ack clear pair mismatch");
  a_reset_loop: assert property ($fell(rst) |-> serial_loopback_select)
    else $error("loopback not forced after reset");
  a_clear_held: assert property (!timeout_clear_n && !cw && !$past(cw) |=> !timeout_clear_n)
    else $error("clear released without a write");
  c_ctl_zero: cover property (cw && wdata == 8'h00);
  c_data_wr: cover property (dw);
  c_reset_out: cover property ($fell(rst));
endmodule
bind bpp_port_map bpp_chk u_chk (.clk, .rst, .wr, .addr, .wdata, .printer_data,
  .printer_strobe_n, .bus_hold_release, .nmi_mask, .nvram_enable, .timeout_clear_n,
  .second_red_indicator, .edge_flag_clear_n, .bus_interrupt_n, .serial_loopback_select,
  .first_red_indicator, .ack_latch_clear_n);
`default_nettype wire

/* testbench/bpp_board_model.sv */
// board side: status lines and serial clock sources
`timescale 1ns/1ps
`default_nettype none
module bpp_board_model
  import bpp_pkg::*;
(
  input wire logic clk,
  input wire bpp_status_s stat,
  input wire logic [5:0] csrc,
  output bpp_status_s pins,
  output logic [5:0] cpins
);
  // no serial controller here; channel software reset stays a host duty
  // lines settle one clock after the bench asks, on the same rising edge the synchronisers sample
  always_ff @(posedge clk) begin
    pins <= stat;
    cpins <= csrc;
  end
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
// bench: register accesses and pin checks for the port map
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
  import bpp_pkg::*;
  logic clk = 0, rst = 1, wr = 0, rd = 0;
  logic [1:0] addr = 0;
  logic [7:0] wdata = 0, rdata, pd;
  bpp_status_s stat = '1, sp;
  logic [5:0] csrc = 0, cp;
  wire logic [10:0] ctl;
  wire logic [3:0] ck;
  logic [7:0] vals[5] = '{8'h0a, 8'ha5, 8'h5a, 8'h00, 8'hff};
  logic [5:0] pats[2] = '{6'h23, 6'h1c};
  int fails = 0, num_checks = 0;
  bpp_board_model u_board (.clk(clk), .stat(stat), .csrc(csrc), .pins(sp), .cpins(cp));
  bpp_port_map u_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .gp_in(sp.gp_in), .printer_acknowledge_n(sp.printer_acknowledge_n),
    .power_fail_sense_n(sp.power_fail_sense_n), .printer_fault_n(sp.printer_fault_n),
    .printer_occupied_n(sp.printer_occupied_n), .printer_data(pd), .printer_strobe_n(ctl[0]),
    .bus_hold_release(ctl[1]), .nmi_mask(ctl[2]), .nvram_enable(ctl[3]),
    .timeout_clear_n(ctl[4]), .second_red_indicator(ctl[5]), .edge_flag_clear_n(ctl[6]),
    .bus_interrupt_n(ctl[7]), .serial_loopback_select(ctl[8]), .first_red_indicator(ctl[9]),
    .ack_latch_clear_n(ctl[10]), .interval_timer_out1(cp[0]), .interval_timer_out2(cp[1]),
    .b_terminal_ready_clk(cp[2]), .b_ext_tx_clk(cp[3]), .a_terminal_ready_clk(cp[4]),
    .a_ext_tx_clk(cp[5]), .b_tx_clk(ck[0]), .b_rx_clk(ck[1]), .a_tx_clk(ck[2]), .a_rx_clk(ck[3]));
  initial begin
    forever #4 clk = ~clk;
  end
  function automatic logic [10:0] ectl(input logic [7:0] v);
    return {v[7], v[7], v[6], v[5], v[4], v[4], v[3], v[3], v[2], v[1], v[0]};
  endfunction
  function automatic logic [3:0] eck(input logic [3:0] s, input logic [5:0] c);
    logic bt, at;
    bt = s[0] ? c[2] : c[0];
    at = s[2] ? c[4] : c[1];
    return {s[3] ? c[5] : at, at, s[1] ? c[3] : bt, bt};
  endfunction
  task automatic wreg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask
  task automatic rreg(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a; rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 `CHK(rdata, e)
  endtask
  task automatic results;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #50us;
    fails++;
    results();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    #1 `CHK(ctl, ectl(RST_BOARD_CTRL))
    rreg(OFS_BOARD_CTRL, RST_BOARD_CTRL);
    foreach (vals[i]) begin
      @(posedge clk) stat <= vals[i];
      wreg(OFS_PRINTER_DATA, vals[i]);
      wreg(OFS_BOARD_CTRL, vals[i]);
      wreg(OFS_STATUS_IN, ~vals[i]);
      repeat (2) @(posedge clk);
      #1 `CHK(pd, vals[i])
      `CHK(ctl, ectl(vals[i]))
      rreg(OFS_PRINTER_DATA, vals[i]);
      rreg(OFS_BOARD_CTRL, vals[i]);
      rreg(OFS_STATUS_IN, vals[i]);
    end
    for (int s = 0; s < 16; s++) begin
      wreg(OFS_CLK_SEL, {4'hf, s[3:0]});
      rreg(OFS_CLK_SEL, {4'h0, s[3:0]});
      foreach (pats[j]) begin
        @(posedge clk) csrc <= pats[j];
        repeat (5) @(posedge clk);
        #1 `CHK(ck, eck(s[3:0], pats[j]))
      end
    end
    results();
  end
endmodule
`default_nettype wire
